// ---- design/cmbc_pkg.sv ----
/*
 * Constants, field positions and carrier types for the CAN message
 * buffer control block and its message memory.
 * Assumes one 100 MHz clock (ref_clk) and a synchronous reset (sys_rst).
 */
package cmbc_pkg;

  // ==========================================================
  // Sizes
  localparam int CMBC_NUM_CTRL = 8;
  localparam int CMBC_NUM_BUFS = 32;
  localparam int CMBC_WORDS = 8;
  localparam int CMBC_MEM_WORDS = CMBC_NUM_BUFS * CMBC_WORDS;

  // ==========================================================
  // Control byte fields
  localparam int CMBC_B_TRANSMIT = 7;
  localparam int CMBC_B_ABORTED = 6;
  localparam int CMBC_B_LOST_ARB = 5;
  localparam int CMBC_B_BUS_ERR = 4;
  localparam int CMBC_B_SEND_REQ = 3;
  localparam int CMBC_B_AUTO_REM = 2;
  localparam logic [7:0] CMBC_CTRL_RESET = 8'h00;

  // ==========================================================
  // Register indexes on the register port
  localparam logic [2:0] CMBC_REG_CTRL0 = 3'h0;
  localparam logic [2:0] CMBC_REG_CTRL3 = 3'h3;
  localparam logic [2:0] CMBC_REG_FULL_LO = 3'h4;
  localparam logic [2:0] CMBC_REG_FULL_HI = 3'h5;
  localparam logic [2:0] CMBC_REG_OVF_LO = 3'h6;
  localparam logic [2:0] CMBC_REG_OVF_HI = 3'h7;

  // ==========================================================
  // Message buffer words and implemented-bit masks
  localparam logic [2:0] CMBC_W_SID = 3'h0;
  localparam logic [2:0] CMBC_W_EID = 3'h1;
  localparam logic [2:0] CMBC_W_DLC = 3'h2;
  localparam logic [2:0] CMBC_W_STAT = 3'h7;
  localparam logic [15:0] CMBC_MASK_SID = 16'h1fff;
  localparam logic [15:0] CMBC_MASK_EID = 16'h0fff;
  localparam logic [15:0] CMBC_MASK_DLC = 16'hff1f;
  localparam logic [15:0] CMBC_MASK_DATA = 16'hffff;
  localparam logic [15:0] CMBC_MASK_STAT = 16'h1f00;
  localparam int CMBC_FILTER_POS = 8;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic [4:0] buf_num;
    logic [2:0] word;
    logic [15:0] wdata;
  } cmbc_mem_req_type;

  typedef struct packed {
    logic valid;
    logic [2:0] buf_num;
    logic success;
    logic aborted;
    logic lost_arb;
    logic bus_err;
  } cmbc_tx_result_type;

  typedef struct packed {
    logic valid;
    logic [4:0] buf_num;
    logic [4:0] filter;
  } cmbc_rx_commit_type;

  typedef struct packed {
    logic [CMBC_NUM_CTRL-1:0][7:0] ctrl;
    logic [CMBC_NUM_CTRL-1:0] abort_pend;
    logic [CMBC_NUM_BUFS-1:0] full;
    logic [CMBC_NUM_BUFS-1:0] ovf;
    logic offer_valid;
    logic [2:0] offer_buf;
    logic [15:0] rdata;
  } cmbc_top_state_type;

  typedef struct packed {
    logic [CMBC_MEM_WORDS-1:0][15:0] mem;
    logic [15:0] a_rdata;
    logic [15:0] b_rdata;
  } cmbc_mem_state_type;

  function automatic logic [15:0] cmbc_word_mask(input logic [2:0] w);
    logic [15:0] m;
    m = CMBC_MASK_DATA;
    if (w == CMBC_W_SID)
      m = CMBC_MASK_SID;
    else if (w == CMBC_W_EID)
      m = CMBC_MASK_EID;
    else if (w == CMBC_W_DLC)
      m = CMBC_MASK_DLC;
    else if (w == CMBC_W_STAT)
      m = CMBC_MASK_STAT;
    return m;
  endfunction

endpackage

// ---- design/cmbc_msg_ram.sv ----
/*
 * Message buffer memory: identifier, length, data and status words
 * for every buffer, with one DMA port and one engine port.
 * Assumes both ports run on ref_clk; engine port wins a same-word clash.
 */
`timescale 1ns/1ps
module cmbc_msg_ram
  import cmbc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire cmbc_mem_req_type a_req, // DMA side request
  output logic [15:0] a_rdata, // DMA side read data
  input wire cmbc_mem_req_type b_req, // Engine side request
  output logic [15:0] b_rdata // Engine side read data
);

  cmbc_mem_state_type st;
  cmbc_mem_state_type next_st;
  logic [7:0] a_idx;
  logic [7:0] b_idx;

  assign a_idx = {a_req.buf_num, a_req.word};
  assign b_idx = {b_req.buf_num, b_req.word};
  assign a_rdata = st.a_rdata;
  assign b_rdata = st.b_rdata;

  // ==========================================================
  // Unimplemented bits are never stored, so they read zero
  always_comb
  begin
    next_st = st;
    next_st.a_rdata = st.mem[a_idx];
    next_st.b_rdata = st.mem[b_idx];
    if (a_req.wr)
      next_st.mem[a_idx] = a_req.wdata & cmbc_word_mask(a_req.word);
    if (b_req.wr)
      next_st.mem[b_idx] = b_req.wdata & cmbc_word_mask(b_req.word);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

// ---- design/cmbc_ctrl.sv ----
/*
 * CAN message buffer control: per-buffer control bytes, send requests
 * with abort, outcome flags, auto remote reply, priority selection,
 * receive full and overflow flags, and the message memory.
 * Assumes a CAN engine on ref_clk that takes offers, reports outcomes
 * and commits received messages; registers reached by a 16-bit port.
 */
`timescale 1ns/1ps
module cmbc_ctrl
  import cmbc_pkg::*;
(
  input wire logic ref_clk, // Clock, 100 MHz
  input wire logic sys_rst, // Sync reset, active high
  input wire logic [2:0] reg_addr, // Register index
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [1:0] reg_be, // Byte enables
  input wire logic [15:0] reg_wdata, // Register write data
  output logic [15:0] reg_rdata, // Register read data
  input wire cmbc_mem_req_type dma_req, // DMA memory request
  output logic [15:0] dma_rdata, // DMA memory read data
  input wire cmbc_mem_req_type eng_req, // Engine memory request
  output logic [15:0] eng_rdata, // Engine memory read data
  output logic tx_offer_valid, // A transmit buffer is pending
  output logic [2:0] tx_offer_buf, // Pending buffer to send
  output logic [CMBC_NUM_CTRL-1:0] tx_abort_pend, // Abort asked
  input wire cmbc_tx_result_type tx_result, // Transmit outcome
  input wire logic remote_rx_valid, // Remote frame matched buffer
  input wire logic [2:0] remote_rx_buf, // Buffer of remote frame
  input wire cmbc_rx_commit_type rx_commit, // Received message stored
  output logic [CMBC_NUM_CTRL-1:0] buf_is_transmit // Direction per buffer
);

  cmbc_top_state_type st;
  cmbc_top_state_type next_st;
  cmbc_mem_req_type ram_b_req;
  logic [CMBC_NUM_CTRL-1:0] eligible;
  logic sel_found;
  logic [2:0] sel_buf;
  logic [1:0] sel_pri;

  assign reg_rdata = st.rdata;
  assign tx_offer_valid = st.offer_valid;
  assign tx_offer_buf = st.offer_buf;
  assign tx_abort_pend = st.abort_pend;

  // ==========================================================
  // Direction bits out to the engine
  genvar g;
  generate
    for (g = 0; g < CMBC_NUM_CTRL; g++)
    begin : g_dir
      assign buf_is_transmit[g] = st.ctrl[g][CMBC_B_TRANSMIT];
      assign eligible[g] = st.ctrl[g][CMBC_B_TRANSMIT]
        & st.ctrl[g][CMBC_B_SEND_REQ] & ~st.abort_pend[g];
    end
  endgenerate

  // ==========================================================
  // Priority pick: ascending scan, >= lets higher numbers win ties
  always_comb
  begin
    sel_found = 1'b0;
    sel_buf = 3'h0;
    sel_pri = 2'h0;
    for (int i = 0; i < CMBC_NUM_CTRL; i++)
    begin
      if (eligible[i] && (!sel_found || st.ctrl[i][1:0] >= sel_pri))
      begin
        sel_found = 1'b1;
        sel_buf = 3'(i);
        sel_pri = st.ctrl[i][1:0];
      end
    end
  end

  // ==========================================================
  // Engine memory port; a commit writes the status word instead
  always_comb
  begin
    ram_b_req = eng_req;
    if (rx_commit.valid)
    begin
      ram_b_req.wr = 1'b1;
      ram_b_req.buf_num = rx_commit.buf_num;
      ram_b_req.word = CMBC_W_STAT;
      ram_b_req.wdata = 16'({rx_commit.filter, 8'h00});
    end
  end

  cmbc_msg_ram u_ram (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .a_req(dma_req),
    .a_rdata(dma_rdata),
    .b_req(ram_b_req),
    .b_rdata(eng_rdata)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [7:0] wb;
    logic [7:0] cur;
    logic hit;
    wb = 8'h00;
    cur = 8'h00;
    hit = 1'b0;
    next_st = st;

    // Software writes to control bytes
    for (int i = 0; i < CMBC_NUM_CTRL; i++)
    begin
      hit = reg_wr && (reg_addr == CMBC_REG_CTRL0 + 3'(i >> 1))
        && reg_be[i % 2];
      wb = (i % 2 == 1) ? reg_wdata[15:8] : reg_wdata[7:0];
      cur = st.ctrl[i];
      if (hit)
      begin
        next_st.ctrl[i][CMBC_B_TRANSMIT] = wb[CMBC_B_TRANSMIT];
        next_st.ctrl[i][CMBC_B_AUTO_REM] = wb[CMBC_B_AUTO_REM];
        next_st.ctrl[i][1:0] = wb[1:0];
        if (wb[CMBC_B_SEND_REQ] && !cur[CMBC_B_SEND_REQ])
        begin
          next_st.ctrl[i][CMBC_B_SEND_REQ] = 1'b1;
          next_st.ctrl[i][CMBC_B_ABORTED] = 1'b0;
          next_st.ctrl[i][CMBC_B_LOST_ARB] = 1'b0;
          next_st.ctrl[i][CMBC_B_BUS_ERR] = 1'b0;
          next_st.abort_pend[i] = 1'b0;
        end
        else if (!wb[CMBC_B_SEND_REQ] && cur[CMBC_B_SEND_REQ])
        begin
          next_st.ctrl[i][CMBC_B_SEND_REQ] = 1'b0;
          next_st.abort_pend[i] = 1'b1;
        end
      end
    end

    // Remote frame answered automatically
    if (remote_rx_valid && st.ctrl[remote_rx_buf][CMBC_B_AUTO_REM])
    begin
      next_st.ctrl[remote_rx_buf][CMBC_B_SEND_REQ] = 1'b1;
      next_st.ctrl[remote_rx_buf][CMBC_B_ABORTED] = 1'b0;
      next_st.ctrl[remote_rx_buf][CMBC_B_LOST_ARB] = 1'b0;
      next_st.ctrl[remote_rx_buf][CMBC_B_BUS_ERR] = 1'b0;
      next_st.abort_pend[remote_rx_buf] = 1'b0;
    end

    // Engine outcomes; hardware sets land after software clears
    if (tx_result.valid)
    begin
      if (tx_result.success)
      begin
        next_st.ctrl[tx_result.buf_num][CMBC_B_SEND_REQ] = 1'b0;
        next_st.ctrl[tx_result.buf_num][CMBC_B_ABORTED] = 1'b0;
      end
      if (tx_result.aborted)
      begin
        next_st.ctrl[tx_result.buf_num][CMBC_B_ABORTED] = 1'b1;
        next_st.ctrl[tx_result.buf_num][CMBC_B_SEND_REQ] = 1'b0;
        next_st.abort_pend[tx_result.buf_num] = 1'b0;
      end
      if (tx_result.lost_arb)
        next_st.ctrl[tx_result.buf_num][CMBC_B_LOST_ARB] = 1'b1;
      if (tx_result.bus_err)
        next_st.ctrl[tx_result.buf_num][CMBC_B_BUS_ERR] = 1'b1;
    end

    // Full and overflow: software writes 0 to clear
    if (reg_wr && reg_addr == CMBC_REG_FULL_LO)
    begin
      if (reg_be[0])
        next_st.full[7:0] = st.full[7:0] & reg_wdata[7:0];
      if (reg_be[1])
        next_st.full[15:8] = st.full[15:8] & reg_wdata[15:8];
    end
    else if (reg_wr && reg_addr == CMBC_REG_FULL_HI)
    begin
      if (reg_be[0])
        next_st.full[23:16] = st.full[23:16] & reg_wdata[7:0];
      if (reg_be[1])
        next_st.full[31:24] = st.full[31:24] & reg_wdata[15:8];
    end
    else if (reg_wr && reg_addr == CMBC_REG_OVF_LO)
    begin
      if (reg_be[0])
        next_st.ovf[7:0] = st.ovf[7:0] & reg_wdata[7:0];
      if (reg_be[1])
        next_st.ovf[15:8] = st.ovf[15:8] & reg_wdata[15:8];
    end
    else if (reg_wr && reg_addr == CMBC_REG_OVF_HI)
    begin
      if (reg_be[0])
        next_st.ovf[23:16] = st.ovf[23:16] & reg_wdata[7:0];
      if (reg_be[1])
        next_st.ovf[31:24] = st.ovf[31:24] & reg_wdata[15:8];
    end

    // Commit sets win over a clear in the same cycle
    if (rx_commit.valid)
    begin
      next_st.full[rx_commit.buf_num] = 1'b1;
      if (st.full[rx_commit.buf_num])
        next_st.ovf[rx_commit.buf_num] = 1'b1;
    end

    // Offer to the engine
    next_st.offer_valid = sel_found;
    next_st.offer_buf = sel_buf;

    // Read data, one cycle after the strobe
    if (reg_rd)
    begin
      if (reg_addr <= CMBC_REG_CTRL3)
        next_st.rdata = {st.ctrl[{reg_addr[1:0], 1'b1}],
                         st.ctrl[{reg_addr[1:0], 1'b0}]};
      else if (reg_addr == CMBC_REG_FULL_LO)
        next_st.rdata = st.full[15:0];
      else if (reg_addr == CMBC_REG_FULL_HI)
        next_st.rdata = st.full[31:16];
      else if (reg_addr == CMBC_REG_OVF_LO)
        next_st.rdata = st.ovf[15:0];
      else
        next_st.rdata = st.ovf[31:16];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.ctrl <= {CMBC_NUM_CTRL{CMBC_CTRL_RESET}};
    end
    else
      st <= next_st;
  end

endmodule

// ---- testbench/cmbc_ctrl_assertions.sv ----
/*
 * Port checks for the CAN message buffer control block.
 * Assumes it is bound to cmbc_ctrl and runs on ref_clk alone.
 */
`timescale 1ns/1ps
module cmbc_ctrl_checker
  import cmbc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic [2:0] reg_addr, // Register index
  input wire logic reg_wr, // Write strobe
  input wire logic [1:0] reg_be, // Byte enables
  input wire logic [15:0] reg_wdata, // Write data
  input wire cmbc_mem_req_type dma_req, // DMA request
  input wire logic [15:0] dma_rdata, // DMA read data
  input wire logic tx_offer_valid, // Offer valid
  input wire logic [2:0] tx_offer_buf, // Offered buffer
  input wire logic [CMBC_NUM_CTRL-1:0] tx_abort_pend, // Abort asks
  input wire cmbc_tx_result_type tx_result, // Outcome
  input wire logic remote_rx_valid, // Remote frame pulse
  input wire cmbc_rx_commit_type rx_commit, // Store pulse
  input wire logic [CMBC_NUM_CTRL-1:0] buf_is_transmit // Direction
);
  logic [7:0] dir_q;
  logic [7:0] ab_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Helpers
  always_ff @(posedge ref_clk)
  begin
    dir_q <= buf_is_transmit;
    ab_q <= tx_abort_pend;
  end

  sequence commit_then_status;
    rx_commit.valid ##1 (!rx_commit.valid && !dma_req.wr &&
      dma_req.word == CMBC_W_STAT &&
      dma_req.buf_num == $past(rx_commit.buf_num));
  endsequence

  // ==========================================================
  // Checks
  chk_dir_low: assert property (
    reg_wr && reg_addr <= CMBC_REG_CTRL3 && reg_be[0] |=>
    buf_is_transmit[{$past(reg_addr[1:0]), 1'b0}] == $past(reg_wdata[7]))
    else $error("even buffer direction not taken from write");
  chk_dir_high: assert property (
    reg_wr && reg_addr <= CMBC_REG_CTRL3 && reg_be[1] |=>
    buf_is_transmit[{$past(reg_addr[1:0]), 1'b1}] == $past(reg_wdata[15]))
    else $error("odd buffer direction not taken from high byte");
  chk_abort_clear: assert property (
    (|($past(tx_abort_pend) & ~tx_abort_pend)) |->
    $past(tx_result.valid && tx_result.aborted) || $past(remote_rx_valid) ||
    $past(reg_wr && reg_addr <= CMBC_REG_CTRL3))
    else $error("abort ask dropped without cause");
  chk_offer_sel: assert property (
    tx_offer_valid |-> dir_q[tx_offer_buf] && !ab_q[tx_offer_buf])
    else $error("offered buffer not a live transmit buffer");
  chk_sid_mask: assert property (
    $past(dma_req.word) == CMBC_W_SID |-> dma_rdata[15:13] == 3'h0)
    else $error("identifier word top bits not zero");
  chk_eid_mask: assert property (
    $past(dma_req.word) == CMBC_W_EID |-> dma_rdata[15:12] == 4'h0)
    else $error("extended word top bits not zero");
  chk_dlc_mask: assert property (
    $past(dma_req.word) == CMBC_W_DLC |-> dma_rdata[7:5] == 3'h0)
    else $error("length word gap bits not zero");
  chk_status_filter: assert property (
    commit_then_status |=>
    dma_rdata == {3'h0, $past(rx_commit.filter, 2), 8'h00})
    else $error("status word does not hold filter number");
endmodule

bind cmbc_ctrl cmbc_ctrl_checker u_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_be(reg_be), .reg_wdata(reg_wdata), .dma_req(dma_req),
  .dma_rdata(dma_rdata), .tx_offer_valid(tx_offer_valid),
  .tx_offer_buf(tx_offer_buf), .tx_abort_pend(tx_abort_pend),
  .tx_result(tx_result), .remote_rx_valid(remote_rx_valid),
  .rx_commit(rx_commit),
  .buf_is_transmit(buf_is_transmit));

// ---- testbench/cmbc_engine_model.sv ----
/*
 * CAN engine stand-in: outcome, remote and store pulses, engine writes.
 * Assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/1ps
module cmbc_engine_model
  import cmbc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic [CMBC_NUM_CTRL-1:0] tx_abort_pend, // Abort asks
  output cmbc_tx_result_type tx_result, // Outcome pulse
  output logic remote_rx_valid, // Remote frame pulse
  output logic [2:0] remote_rx_buf, // Remote frame buffer
  output cmbc_rx_commit_type rx_commit, // Store pulse
  output cmbc_mem_req_type eng_req // Engine memory access
);
  initial
  begin
    tx_result = '0;
    remote_rx_valid = 1'b0;
    remote_rx_buf = 3'h0;
    rx_commit = '0;
    eng_req = '0;
  end

  // ==========================================================
  // Transfers
  task automatic step(input int d);
    repeat (d) @(posedge ref_clk);
    #1;
  endtask

  task automatic outcome(input logic [2:0] b, input logic [3:0] k,
    input int d);
    step(d);
    // Abort answered only while asked
    tx_result = {1'b1, b, k[3], k[2] & tx_abort_pend[b], k[1:0]};
    step(1);
    tx_result = '0;
  endtask

  task automatic remote(input logic [2:0] b);
    step(1);
    remote_rx_valid = 1'b1;
    remote_rx_buf = b;
    step(1);
    remote_rx_valid = 1'b0;
    remote_rx_buf = ~b;
  endtask

  task automatic commit(input logic [4:0] b, input logic [4:0] f);
    step(1);
    rx_commit = {1'b1, b, f};
    step(1);
    rx_commit = {1'b0, ~b, ~f};
  endtask

  task automatic eng_write(input logic [4:0] b, input logic [2:0] w,
    input logic [15:0] d);
    step(1);
    eng_req = {1'b1, b, w,
      (w == CMBC_W_DLC) ? (d & 16'hfeef) : d};
    step(1);
    eng_req = {1'b0, ~b, w, ~d};
  endtask

  task automatic eng_read(input logic [4:0] b, input logic [2:0] w);
    step(1);
    eng_req = {1'b0, b, w, 16'h0000};
    step(1);
  endtask
endmodule

// ---- testbench/can_message_buffer_control_tb.sv ----
/*
 * Self-checking bench for cmbc_ctrl: register calls, DMA memory calls
 * and engine model calls with expected values.
 * Assumes the checker is bound to the design by its own file.
 */
`timescale 1ns/1ps
module can_message_buffer_control_tb
  import cmbc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  cmbc_mem_req_type dma_req = '0;
  logic [15:0] dma_rdata;
  cmbc_mem_req_type eng_req;
  logic [15:0] eng_rdata;
  logic tx_offer_valid;
  logic [2:0] tx_offer_buf;
  logic [7:0] tx_abort_pend;
  cmbc_tx_result_type tx_result;
  logic remote_rx_valid;
  logic [2:0] remote_rx_buf;
  cmbc_rx_commit_type rx_commit;
  logic [7:0] buf_is_transmit;
  int bad_count = 0;
  int samples_checked = 0;
  logic [15:0] wmask [8] = '{16'h1fff, 16'h0fff, 16'hff1f, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'h1f00};

  always #5 ref_clk = ~ref_clk;

  cmbc_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dma_req(dma_req), .dma_rdata(dma_rdata), .eng_req(eng_req),
    .eng_rdata(eng_rdata), .tx_offer_valid(tx_offer_valid),
    .tx_offer_buf(tx_offer_buf), .tx_abort_pend(tx_abort_pend),
    .tx_result(tx_result), .remote_rx_valid(remote_rx_valid),
    .remote_rx_buf(remote_rx_buf), .rx_commit(rx_commit),
    .buf_is_transmit(buf_is_transmit));

  cmbc_engine_model eng (.ref_clk(ref_clk), .tx_abort_pend(tx_abort_pend),
    .tx_result(tx_result), .remote_rx_valid(remote_rx_valid),
    .remote_rx_buf(remote_rx_buf), .rx_commit(rx_commit),
    .eng_req(eng_req));

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [1:0] be,
    input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_addr, reg_be, reg_wdata} = {1'b1, a, be, d};
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask

  task automatic dma_acc(input logic w, input logic [4:0] b,
    input logic [2:0] wd, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    dma_req = {w, b, wd, d};
    @(posedge ref_clk);
    #1;
    dma_req.wr = 1'b0;
  endtask

  task automatic offer_chk(input logic [2:0] b);
    @(posedge ref_clk);
    #1;
    chk({12'h000, tx_offer_valid, tx_offer_buf}, {12'h000, 1'b1, b});
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++)
      reg_read(i[2:0], 16'h0000);
    reg_write(3'h0, 2'b11, 16'h89fb);
    reg_read(3'h0, 16'h898b);
    offer_chk(3'h0);
    reg_write(3'h1, 2'b11, 16'h8b8a);
    offer_chk(3'h3);
    eng.outcome(3'h3, 4'b0010, 1);
    reg_read(3'h1, 16'hab8a);
    eng.outcome(3'h3, 4'b0001, 2);
    reg_read(3'h1, 16'hbb8a);
    eng.outcome(3'h3, 4'b1000, 1);
    reg_read(3'h1, 16'hb38a);
    reg_write(3'h1, 2'b10, 16'hfb00);
    reg_read(3'h1, 16'h8b8a);
    reg_write(3'h1, 2'b10, 16'h8300);
    chk({8'h00, tx_abort_pend}, 16'h0008);
    reg_read(3'h1, 16'h838a);
    eng.outcome(3'h3, 4'b0100, 3);
    reg_read(3'h1, 16'hc38a);
    chk({8'h00, tx_abort_pend}, 16'h0000);
    reg_write(3'h0, 2'b01, 16'h0083);
    offer_chk(3'h2);
    reg_write(3'h2, 2'b11, 16'h0084);
    eng.remote(3'h4);
    reg_read(3'h2, 16'h008c);
    eng.remote(3'h5);
    reg_read(3'h2, 16'h008c);
    chk({8'h00, buf_is_transmit}, 16'h001f);
    for (int w = 0; w < 8; w++)
    begin
      dma_acc(1'b1, 5'd7, w[2:0], 16'hffff);
      dma_acc(1'b0, 5'd7, w[2:0], 16'h0000);
      chk(dma_rdata, wmask[w]);
    end
    eng.eng_write(5'd12, CMBC_W_DLC, 16'hffff);
    dma_acc(1'b0, 5'd12, CMBC_W_DLC, 16'h0000);
    chk(dma_rdata, 16'hfe0f);
    eng.eng_read(5'd12, CMBC_W_DLC);
    chk(eng_rdata, 16'hfe0f);
    dma_req = {1'b0, 5'd9, CMBC_W_STAT, 16'h0000};
    eng.commit(5'd9, 5'h15);
    @(posedge ref_clk);
    #1;
    chk(dma_rdata, 16'h1500);
    reg_read(3'h4, 16'h0200);
    reg_read(3'h6, 16'h0000);
    eng.commit(5'd9, 5'h0a);
    reg_read(3'h6, 16'h0200);
    eng.commit(5'd20, 5'h1f);
    reg_read(3'h5, 16'h0010);
    reg_write(3'h4, 2'b11, 16'h0000);
    reg_read(3'h4, 16'h0000);
    test_done();
  end
endmodule
